/* rtl/icp_pkg.sv */
package icp_pkg;

  // Bus widths and stack depth of the core.
  localparam int ICP_INSN_W  = 14;
  localparam int ICP_DATA_W  = 8;
  localparam int ICP_PC_W    = 11;
  localparam int ICP_STACK_D = 8;

  // Phase counter codes; four phases make one instruction cycle.
  localparam logic [1:0] ICP_PH_ONE   = 2'h0;
  localparam logic [1:0] ICP_PH_TWO   = 2'h1;
  localparam logic [1:0] ICP_PH_THREE = 2'h2;
  localparam logic [1:0] ICP_PH_FOUR  = 2'h3;

  // Reset values.
  localparam logic [ICP_PC_W-1:0]   ICP_PC_RST   = 11'h000;
  localparam logic [ICP_INSN_W-1:0] ICP_NOP_WORD = 14'h0000;

  // Flow-change request kinds from the decoder.
  typedef enum logic [1:0] {
    ICP_FLOW_SEQ,
    ICP_FLOW_JUMP,
    ICP_FLOW_CALL,
    ICP_FLOW_RET
  } icp_flow_t;

  // Decoder answer for the instruction in execute.
  typedef struct packed {
    icp_flow_t             flow;
    logic [ICP_PC_W-1:0]   target;
    logic                  wr_en;
    logic [ICP_DATA_W-1:0] wr_data;
  } icp_exec_t;

  // Phase strobes, one-hot.
  typedef struct packed {
    logic one;
    logic two;
    logic three;
    logic four;
  } icp_phase_t;

endpackage

/* rtl/icp_stack.sv */
`timescale 1ns/100ps

// Circular return-address stack; overflow wraps and overwrites the oldest.
module icp_stack
  import icp_pkg::*;
#(
  parameter int DEPTH = ICP_STACK_D,
  parameter int WIDTH = ICP_PC_W
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic [WIDTH-1:0] push_data,
  output logic      [WIDTH-1:0] top_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    ptr_reg;

  // Top of stack sits one below the write pointer.
  assign top_data = mem_reg[ptr_reg - PW'(1)];

  // Pointer moves on push or pop; wrapping mirrors the hardware stack.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ptr_reg <= '0;
    end else if (push) begin
      ptr_reg <= ptr_reg + PW'(1);
    end else if (pop) begin
      ptr_reg <= ptr_reg - PW'(1);
    end
  end

  // Storage needs no reset; an empty pop simply returns stale data.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[ptr_reg] <= push_data;
    end
  end

endmodule

/* rtl/icp_core.sv */
`timescale 1ns/100ps

// Function
// - Divide the oscillator clock by four into four non-overlapping phases.
// - Load the program counter with plus one, a target or the return address in phase one of each cycle, except the no-op slot after a flow change.
// - Capture the fetched program word into the instruction latch in phase four.
// - Decode and execute an instruction over the following full cycle.
// - Fetch overlaps execute; flow changes take two instruction cycles.
// - Separate 14-bit program bus and 8-bit data bus.
// - Eight-deep hardware return-address stack.
// - Read data operand in phase two, write result in phase four.
module icp_core
  import icp_pkg::*;
#(
  parameter int PC_W    = ICP_PC_W,
  parameter int STACK_D = ICP_STACK_D
) (
  input  wire logic                  CLOCK,
  input  wire logic                  RST_B,
  output logic      [PC_W-1:0]       PROG_ADDR,
  output logic                       PROG_RD,
  input  wire logic [ICP_INSN_W-1:0] PROG_DATA,
  output logic      [ICP_INSN_W-1:0] EXEC_INSN,
  output logic                       EXEC_VALID,
  input  wire icp_exec_t             EXEC_CTRL,
  output logic                       DATA_RD,
  input  wire logic [ICP_DATA_W-1:0] DATA_RDATA,
  output logic      [ICP_DATA_W-1:0] DATA_OPERAND,
  output logic                       DATA_WR,
  output logic      [ICP_DATA_W-1:0] DATA_WDATA,
  output icp_phase_t                 PHASE,
  output logic      [PC_W-1:0]       PC
);

  logic [1:0]            phase_reg;
  logic [PC_W-1:0]       pc_reg;
  logic [PC_W-1:0]       pc_next;
  logic [ICP_INSN_W-1:0] exec_reg;
  logic                  exec_ok_reg;
  logic                  flush_reg;
  logic [ICP_DATA_W-1:0] operand_reg;
  logic                  flow_chg;
  logic [PC_W-1:0]       ret_addr;
  logic                  ph_one;
  logic                  ph_two;
  logic                  ph_three;
  logic                  ph_four;

  // Divide by four with a free-running two-bit phase counter.
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      phase_reg <= ICP_PH_ONE;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  assign ph_one  = (phase_reg == ICP_PH_ONE);
  assign ph_two   = (phase_reg == ICP_PH_TWO);
  assign ph_three = (phase_reg == ICP_PH_THREE);
  assign ph_four  = (phase_reg == ICP_PH_FOUR);
  // Decoded from one counter, so the phases can never overlap.
  assign PHASE = '{one: ph_one, two: ph_two,
                   three: ph_three, four: ph_four};

  // A flow change is only honoured for a valid instruction in execute.
  assign flow_chg = exec_ok_reg && (EXEC_CTRL.flow != ICP_FLOW_SEQ);

  // Next program counter: the target, a return address, or plus one.
  always_comb begin
    unique case (EXEC_CTRL.flow)
      ICP_FLOW_JUMP, ICP_FLOW_CALL: pc_next = EXEC_CTRL.target;
      ICP_FLOW_RET:                 pc_next = ret_addr;
      ICP_FLOW_SEQ:                 pc_next = pc_reg + PC_W'(1);
    endcase
    if (!exec_ok_reg) begin
      pc_next = pc_reg + PC_W'(1);
    end
  end

  // The counter moves in phase one only; a jump lands in the same slot.
  // In the no-op slot after a flow change it holds, so the target word
  // dropped by the flush is fetched a second time.
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      pc_reg <= ICP_PC_RST;
    end else if (ph_one && !flush_reg) begin
      pc_reg <= pc_next;
    end
  end

  // Program memory is addressed with the counter; fetch strobe in phase four.
  assign PROG_ADDR = pc_reg;
  assign PROG_RD   = ph_four;
  assign PC        = pc_reg;

  // Flush is armed by a flow change in phase one and lasts one cycle.
  // The word fetched then already comes from the target, but its slot is
  // the branch penalty, so it is dropped and fetched again next cycle.
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      flush_reg <= 1'b0;
    end else if (ph_one) begin
      flush_reg <= flow_chg;
    end
  end

  // Instruction register takes the fetched word at the end of phase four,
  // so it executes over the whole following cycle.
  // A flushed word becomes a no-op cycle, so branches cost two.
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      exec_reg    <= ICP_NOP_WORD;
      exec_ok_reg <= 1'b0;
    end else if (ph_four) begin
      if (flush_reg) begin
        exec_reg <= ICP_NOP_WORD;
      end else begin
        exec_reg <= PROG_DATA;
      end
      exec_ok_reg <= !flush_reg;
    end
  end

  assign EXEC_INSN  = exec_reg;
  assign EXEC_VALID = exec_ok_reg;

  // Operand read strobes in phase two and is held for the cycle.
  assign DATA_RD = exec_ok_reg && ph_two;
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      operand_reg <= '0;
    end else if (DATA_RD) begin
      operand_reg <= DATA_RDATA;
    end
  end
  assign DATA_OPERAND = operand_reg;

  // Destination write in phase four; data registered for a clean bus.
  assign DATA_WR = exec_ok_reg && ph_four && EXEC_CTRL.wr_en;
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      DATA_WDATA <= '0;
    end else if (exec_ok_reg && ph_three) begin
      DATA_WDATA <= EXEC_CTRL.wr_data;
    end
  end

  // Calls push the return address, returns pop it, in phase one.
  // The return address is the word after the call, not the call itself.
  icp_stack #(
    .DEPTH (STACK_D),
    .WIDTH (PC_W)
  ) u_stack (
    .clk       (CLOCK),
    .rst_b     (RST_B),
    .push      (ph_one && exec_ok_reg
                && EXEC_CTRL.flow == ICP_FLOW_CALL),
    .pop       (ph_one && exec_ok_reg
                && EXEC_CTRL.flow == ICP_FLOW_RET),
    .push_data (pc_reg + PC_W'(1)),
    .top_data  (ret_addr)
  );

endmodule

/* sim/icp_props.sv */
`timescale 1ns/100ps
// Phase and strobe relations seen from the core's own ports.
module icp_props
  import icp_pkg::*;
#(parameter int PC_W = ICP_PC_W) (
  input wire logic                  CLOCK,
  input wire logic                  RST_B,
  input wire logic [PC_W-1:0]       PROG_ADDR,
  input wire logic                  PROG_RD,
  input wire logic [ICP_INSN_W-1:0] EXEC_INSN,
  input wire logic                  EXEC_VALID,
  input wire icp_exec_t             EXEC_CTRL,
  input wire logic                  DATA_RD,
  input wire logic                  DATA_WR,
  input wire icp_phase_t            PHASE,
  input wire logic [PC_W-1:0]       PC
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  property p_hot; $onehot(PHASE); endproperty
  a_hot: assert property (p_hot) else $error("phase not one-hot");
  property p_rot;
    RST_B && PHASE.one
      |=> PHASE.two ##1 PHASE.three ##1 PHASE.four ##1 PHASE.one;
  endproperty
  a_rot: assert property (p_rot) else $error("phase order");
  property p_pc; $changed(PC) |-> $past(PHASE.one); endproperty
  a_pc: assert property (p_pc) else $error("pc moved late");
  property p_fet; PROG_RD == PHASE.four && PROG_ADDR == PC; endproperty
  a_fet: assert property (p_fet) else $error("fetch strobe");
  property p_hold; !PHASE.one |-> $stable(EXEC_VALID); endproperty
  a_hold: assert property (p_hold) else $error("valid moved");
  property p_rd; DATA_RD == (PHASE.two && EXEC_VALID); endproperty
  a_rd: assert property (p_rd) else $error("operand read");
  property p_wr; DATA_WR |-> PHASE.four && EXEC_VALID; endproperty
  a_wr: assert property (p_wr) else $error("result write");
  property p_br;
    PHASE.one && EXEC_VALID && EXEC_CTRL.flow inside
      {ICP_FLOW_JUMP, ICP_FLOW_CALL} |=> PC == $past(EXEC_CTRL.target);
  endproperty
  a_br: assert property (p_br) else $error("branch target");
  property p_nop;
    PHASE.one && EXEC_VALID && EXEC_CTRL.flow != ICP_FLOW_SEQ
      |-> ##4 !EXEC_VALID && EXEC_INSN == ICP_NOP_WORD;
  endproperty
  a_nop: assert property (p_nop) else $error("no flush slot");
endmodule

bind icp_core icp_props #(.PC_W(PC_W)) icp_props_i (
  .CLOCK(CLOCK), .RST_B(RST_B), .PROG_ADDR(PROG_ADDR),
  .PROG_RD(PROG_RD), .EXEC_INSN(EXEC_INSN), .EXEC_VALID(EXEC_VALID),
  .EXEC_CTRL(EXEC_CTRL), .DATA_RD(DATA_RD), .DATA_WR(DATA_WR),
  .PHASE(PHASE), .PC(PC));

/* sim/icp_mem_model.sv */
`timescale 1ns/100ps
// Program memory, data memory and decoder on the core's far side.
module icp_mem_model
  import icp_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic [ICP_PC_W-1:0]   prog_addr,
  input  wire logic                  prog_rd,
  input  wire logic [ICP_INSN_W-1:0] exec_insn,
  input  wire logic                  data_rd,
  input  wire logic [ICP_DATA_W-1:0] data_operand,
  output logic      [ICP_INSN_W-1:0] prog_data,
  output icp_exec_t                  exec_ctrl,
  output logic      [ICP_DATA_W-1:0] data_rdata
);
  logic [7:0] tick_reg = 8'h00;
  // Idle buses move every clock, so stale data never passes for an answer.
  always @(posedge clk) tick_reg <= tick_reg + 8'h01;
  // A jump at 3, a call at 9 into a return at 16; others write.
  function automatic logic [13:0] word(input logic [10:0] a);
    case (a)
      11'h003: word = {ICP_FLOW_JUMP, 1'b0, 11'h008};
      11'h009: word = {ICP_FLOW_CALL, 1'b0, 11'h010};
      11'h010: word = {ICP_FLOW_RET, 1'b0, 11'h000};
      default: word = {ICP_FLOW_SEQ, 1'b1, a};
    endcase
  endfunction
  // The decoder is a pure function of the word and operand.
  assign prog_data = prog_rd ? word(prog_addr) : {tick_reg[5:0], ~tick_reg};
  assign exec_ctrl = '{flow: icp_flow_t'(exec_insn[13:12]),
    target: exec_insn[10:0], wr_en: exec_insn[11],
    wr_data: data_operand + 8'h01};
  assign data_rdata = data_rd ? exec_insn[7:0] ^ 8'hA5 : tick_reg;
endmodule

/* sim/icp_core_tb.sv */
`timescale 1ns/100ps
// Self-checking bench for the instruction phase sequencer.
module icp_core_tb;
  import icp_pkg::*;
  logic             CLOCK = 1'b0;
  logic             RST_B = 1'b0;
  logic [10:0]      PROG_ADDR, PC;
  logic             PROG_RD, EXEC_VALID, DATA_RD, DATA_WR;
  logic [13:0]      PROG_DATA, EXEC_INSN;
  logic [7:0]       DATA_RDATA, DATA_OPERAND, DATA_WDATA;
  icp_exec_t        EXEC_CTRL;
  icp_phase_t       PHASE;
  int               fails = 0;
  int               checked = 0;
  logic [10:0]      seen_q[$];
  always #25 CLOCK = ~CLOCK;
  icp_core icp_core_i (.CLOCK(CLOCK), .RST_B(RST_B),
    .PROG_ADDR(PROG_ADDR), .PROG_RD(PROG_RD), .PROG_DATA(PROG_DATA),
    .EXEC_INSN(EXEC_INSN), .EXEC_VALID(EXEC_VALID), .EXEC_CTRL(EXEC_CTRL),
    .DATA_RD(DATA_RD), .DATA_RDATA(DATA_RDATA),
    .DATA_OPERAND(DATA_OPERAND), .DATA_WR(DATA_WR),
    .DATA_WDATA(DATA_WDATA), .PHASE(PHASE), .PC(PC));
  icp_mem_model icp_mem_model_i (.clk(CLOCK), .prog_addr(PROG_ADDR),
    .prog_rd(PROG_RD), .exec_insn(EXEC_INSN), .data_rd(DATA_RD),
    .data_operand(DATA_OPERAND), .prog_data(PROG_DATA),
    .exec_ctrl(EXEC_CTRL), .data_rdata(DATA_RDATA));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %0t %h %h", $time, seen, exp);
    end
  endtask
  task close_out;
    if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Log each cycle's word in execute; no-op slots log as all ones.
  always @(posedge CLOCK) begin
    if (RST_B && PHASE.one)
      seen_q.push_back(EXEC_VALID ? EXEC_INSN[10:0] : 11'h7FF);
    if (RST_B && DATA_WR) begin
      chk(DATA_OPERAND, 8'(EXEC_INSN[7:0] ^ 8'hA5));
      chk(DATA_WDATA, 8'((EXEC_INSN[7:0] ^ 8'hA5) + 8'h01));
    end
  end
  // Hold reset, check the idle state, then release and clear the log.
  task t_reset(input int n);
    RST_B <= 1'b0;
    repeat (n - 1) @(posedge CLOCK);
    #1;
    chk(PC, 16'h0000);
    chk(PHASE, 16'h0008);
    chk(EXEC_VALID, 16'h0000);
    @(posedge CLOCK);
    seen_q.delete();
    RST_B <= 1'b1;
  endtask
  // Jump, call and return each leave exactly one empty slot behind.
  task t_flow;
    logic [10:0] e [11];
    int          i;
    e = '{11'h001, 11'h002, 11'h008, 11'h7FF, 11'h008, 11'h010,
          11'h7FF, 11'h000, 11'h7FF, 11'h00A, 11'h00B};
    for (i = 0; i < 400 && seen_q.size() < 14; i++) @(posedge CLOCK);
    if (seen_q.size() < 14) begin
      fails++;
    end else begin
      while (seen_q.size() > 11 && seen_q[0] === 11'h7FF)
        void'(seen_q.pop_front());
      for (i = 0; i < 11; i++) chk(seen_q[i], e[i]);
    end
  endtask
  initial begin
    t_reset(12);
    t_flow;
    t_reset(4);
    t_flow;
    close_out;
  end
endmodule
